// File: core/tcd_pkg.sv
// Shared constants and types of the two-channel cycle-steal transfer engine
package tcd_pkg;

    localparam int NUM_CH = 2;
    localparam int ADDR_W = 20;
    localparam int CNT_W = 16;
    localparam int DATA_W = 16;
    localparam int SRC_W = 32;
    localparam int FIFO_WIDTH = 16;
    localparam int FIFO_DEPTH = 8;

    // Request source indices, {source_bank_select, source_select_field}
    localparam logic [4:0] SRC_PIN_FALL = 5'h00;
    localparam logic [4:0] SRC_SOFTWARE = 5'h01;
    localparam logic [4:0] SRC_PIN_BOTH = 5'h17;

    // Values after reset and fixed figures
    localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_TERMINAL = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] STEP_BYTE = 20'h00001;
    localparam logic [ADDR_W-1:0] STEP_WORD = 20'h00002;
    localparam logic [1:0] BE_NONE = 2'h0;
    localparam logic [1:0] BE_LOW = 2'h1;
    localparam logic [1:0] BE_HIGH = 2'h2;
    localparam logic [1:0] BE_WORD = 2'h3;

    // Per-channel configuration, held as levels by software
    typedef struct packed {
        logic channel_enable_bit;
        logic repeat_mode;
        logic unit_size_bit;
        logic src_forward;
        logic dst_forward;
        logic source_bank_select;
        logic [3:0] source_select_field;
        logic [ADDR_W-1:0] source_address_reg;
        logic [ADDR_W-1:0] destination_address_reg;
        logic [CNT_W-1:0] counter_reload;
    } tcd_cfg_t;

    // Per-channel one-cycle software strobes
    typedef struct packed {
        logic sw_request;
        logic status_clear;
    } tcd_cmd_t;

    // Per-channel state shown to software
    typedef struct packed {
        logic request_status_bit;
        logic active;
        logic cfg_error;
        logic done_irq;
        logic [CNT_W-1:0] counter;
        logic [ADDR_W-1:0] pointer;
    } tcd_stat_t;

    // Shared system bus, driven by the engine while it holds the bus
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic rd;
        logic wr;
        logic [1:0] be;
        logic [DATA_W-1:0] wdata;
    } tcd_bus_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD,
        ST_RWAIT,
        ST_RCAP,
        ST_PUSH,
        ST_WR,
        ST_WWAIT,
        ST_UPD
    } tcd_state_t;

endpackage

// File: core/tcd_fifo.sv
// Small first-in first-out buffer between read and write phases
module tcd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign in_ready = (count_q != FULL_COUNT);
    assign out_valid = (count_q != '0);
    assign out_data = mem_q[rd_ptr_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk)
    begin
        if (push)
            mem_q[wr_ptr_q] <= in_data;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= (wr_ptr_q == LAST_SLOT) ? '0 : wr_ptr_q + 1'b1;
            if (pop)
                rd_ptr_q <= (rd_ptr_q == LAST_SLOT) ? '0 : rd_ptr_q + 1'b1;
            if (push && !pop)
                count_q <= count_q + 1'b1;
            else if (pop && !push)
                count_q <= count_q - 1'b1;
        end
    end

endmodule // tcd_fifo

// File: core/tcd_engine.sv
// Two-channel cycle-steal transfer engine
// Summary of operation
// - Two independent channels, each stealing single bus cycles, never bursts.
// - Each accepted request moves exactly one byte or one 16-bit word.
// - Engine takes the shared bus ahead of the processor whenever work pends.
// - Request comes from the software strobe or the selected source event.
// - Requests ignore processor interrupt masking and per-source interrupt settings.
// - Transfers never touch the source's interrupt pending flag.
// - Requests start transfers only while the channel enable bit is one.
// - Requests faster than transfers merge; fewer transfers than requests is allowed.
// - Pointers are fixed or incrementing over 1M bytes; both incrementing is forbidden.
// - Counter allows 128K bytes in word units, 64K bytes in byte units.
// - Channel zero is served first when both channels have work.
// - Sources include pin edges, timers, serial ports, conversion done, software.
// - Single mode finishes and stops when the counter underflows.
// - Repeat mode reloads the counter on underflow and keeps going.
// - Each channel pulses its completion request on counter underflow.
// - Clearing enable stops a channel; single mode also stops after underflow.
// - First transfer after enable loads pointer and counter from their registers.
// - Software may clear the request status bit; writing one does nothing.
// - Word unit at an odd address costs one extra bus cycle per phase.
module tcd_engine
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Channel configuration and software strobes
    input tcd_pkg::tcd_cfg_t [tcd_pkg::NUM_CH-1:0] cfg,
    input tcd_pkg::tcd_cmd_t [tcd_pkg::NUM_CH-1:0] cmd,
    // Request sources
    input wire logic ext_irq_pin_zero,
    input wire logic ext_irq_pin_one,
    input wire logic [tcd_pkg::NUM_CH-1:0][tcd_pkg::SRC_W-1:0] periph_irq,
    // Shared system bus
    output logic bus_hold,
    output tcd_pkg::tcd_bus_t bus_out,
    input wire logic [tcd_pkg::DATA_W-1:0] bus_rdata,
    // Channel status
    output tcd_pkg::tcd_stat_t [tcd_pkg::NUM_CH-1:0] status
);
    import tcd_pkg::*;
    logic [NUM_CH-1:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_fall, pin_both, req_ev, pend_q;
    logic [NUM_CH-1:0] en_q, first_q, done_q, irq_q, bad, ready, take;
    logic [NUM_CH-1:0][CNT_W-1:0] cnt_q;
    logic [NUM_CH-1:0][ADDR_W-1:0] ptr_q;
    tcd_state_t state_q;
    logic cur_q, pick, start, part_q, unit16_q, repeat_q, src_fwd_q;
    logic [ADDR_W-1:0] src_q, dst_q, base_ptr, rd_addr, wr_addr;
    logic [CNT_W-1:0] cnt_cur_q;
    logic [DATA_W-1:0] data_q;
    logic rd_split, wr_split, rd_byte, wr_byte, bus_hold_q, fifo_in_ready, fifo_out_valid;
    logic [7:0] rd_lane, wr_byte_val;
    tcd_bus_t bus_q;
    logic [FIFO_WIDTH-1:0] fifo_out_data;
    // Pins come from outside the clock domain
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pin_s1_q <= '1;
            pin_s2_q <= '1;
            pin_s3_q <= '1;
        end
        else
        begin
            pin_s1_q <= {ext_irq_pin_one, ext_irq_pin_zero};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end
    assign pin_fall = pin_s3_q & ~pin_s2_q;
    assign pin_both = pin_s3_q ^ pin_s2_q;
    // Source decode; interrupt masks never enter here
    always_comb
    begin
        for (int ch = 0; ch < NUM_CH; ch++)
        begin
            case ({cfg[ch].source_bank_select, cfg[ch].source_select_field})
                SRC_PIN_FALL: req_ev[ch] = pin_fall[ch];
                SRC_SOFTWARE: req_ev[ch] = 1'b0;
                SRC_PIN_BOTH: req_ev[ch] = pin_both[ch];
                default: req_ev[ch] = periph_irq[ch][{cfg[ch].source_bank_select,
                    cfg[ch].source_select_field}];
            endcase
            req_ev[ch] = req_ev[ch] | cmd[ch].sw_request;
        end
    end

    // Both pointers forward is refused rather than guessed at
    always_comb
    begin
        for (int ch = 0; ch < NUM_CH; ch++)
        begin
            bad[ch] = cfg[ch].src_forward && cfg[ch].dst_forward;
            ready[ch] = pend_q[ch] && cfg[ch].channel_enable_bit && !bad[ch] && !done_q[ch];
        end
    end
    assign pick = ready[0] ? 1'b0 : 1'b1;
    assign start = (state_q == ST_IDLE) && (ready != '0);
    assign take = start ? (pick ? 2'b10 : 2'b01) : 2'b00;
    // Request latch: one bit, so bursts of requests merge; a new request beats a clear
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            pend_q <= '0;
        else
        begin
            for (int ch = 0; ch < NUM_CH; ch++)
            begin
                if (req_ev[ch] && cfg[ch].channel_enable_bit && !done_q[ch])
                    pend_q[ch] <= 1'b1;
                else if (cmd[ch].status_clear || take[ch])
                    pend_q[ch] <= 1'b0;
                else if (!cfg[ch].channel_enable_bit)
                    pend_q[ch] <= 1'b0;
            end
        end
    end

    // Enable edge arms the reload of pointer and counter
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            en_q <= '0;
            first_q <= '0;
            done_q <= '0;
        end
        else
        begin
            for (int ch = 0; ch < NUM_CH; ch++)
            begin
                en_q[ch] <= cfg[ch].channel_enable_bit;
                if (cfg[ch].channel_enable_bit && !en_q[ch])
                begin
                    first_q[ch] <= 1'b1;
                    done_q[ch] <= 1'b0;
                end
                else if (take[ch])
                    first_q[ch] <= 1'b0;
                if (state_q == ST_UPD && cur_q == ch[0] && cnt_cur_q == CNT_TERMINAL
                    && !repeat_q)
                    done_q[ch] <= 1'b1;
            end
        end
    end

    assign base_ptr = first_q[pick]
        ? (cfg[pick].src_forward ? cfg[pick].source_address_reg
                                 : cfg[pick].destination_address_reg)
        : ptr_q[pick];

    assign rd_split = unit16_q && src_q[0];
    assign wr_split = unit16_q && dst_q[0];
    assign rd_byte = !unit16_q || src_q[0];
    assign wr_byte = !unit16_q || dst_q[0];
    assign rd_addr = src_q + ADDR_W'(part_q);
    assign wr_addr = dst_q + ADDR_W'(part_q);
    assign rd_lane = rd_addr[0] ? bus_rdata[15:8] : bus_rdata[7:0];
    assign wr_byte_val = part_q ? fifo_out_data[15:8] : fifo_out_data[7:0];

    // Transfer sequencer: one datum per grant, then the bus returns unless a channel is ready
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= ST_IDLE;
            cur_q <= 1'b0;
            part_q <= 1'b0;
            unit16_q <= 1'b0;
            repeat_q <= 1'b0;
            src_fwd_q <= 1'b0;
            src_q <= ADDR_RST;
            dst_q <= ADDR_RST;
            cnt_cur_q <= CNT_RST;
            data_q <= DATA_RST;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                    if (start)
                    begin
                        cur_q <= pick;
                        part_q <= 1'b0;
                        unit16_q <= !cfg[pick].unit_size_bit;
                        repeat_q <= cfg[pick].repeat_mode;
                        src_fwd_q <= cfg[pick].src_forward;
                        src_q <= cfg[pick].src_forward ? base_ptr
                                                       : cfg[pick].source_address_reg;
                        dst_q <= cfg[pick].dst_forward ? base_ptr
                                                       : cfg[pick].destination_address_reg;
                        cnt_cur_q <= first_q[pick] ? cfg[pick].counter_reload
                                                   : cnt_q[pick];
                        data_q <= DATA_RST;
                        state_q <= ST_RD;
                    end
                ST_RD:
                    state_q <= ST_RWAIT;
                ST_RWAIT:
                    state_q <= ST_RCAP;
                ST_RCAP:
                begin
                    if (!rd_byte)
                        data_q <= bus_rdata;
                    else if (part_q)
                        data_q[15:8] <= rd_lane;
                    else
                        data_q[7:0] <= rd_lane;
                    if (rd_split && !part_q)
                    begin
                        part_q <= 1'b1;
                        state_q <= ST_RD;
                    end
                    else
                        state_q <= ST_PUSH;
                end
                ST_PUSH:
                    if (fifo_in_ready)
                    begin
                        part_q <= 1'b0;
                        state_q <= ST_WR;
                    end
                ST_WR:
                    if (fifo_out_valid)
                        state_q <= ST_WWAIT;
                ST_WWAIT:
                    if (wr_split && !part_q)
                    begin
                        part_q <= 1'b1;
                        state_q <= ST_WR;
                    end
                    else
                        state_q <= ST_UPD;
                ST_UPD:
                    state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // Per-channel counter and pointer write-back
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cnt_q <= '0;
            ptr_q <= '0;
            irq_q <= '0;
        end
        else
        begin
            irq_q <= '0;
            if (state_q == ST_UPD)
            begin
                ptr_q[cur_q] <= (src_fwd_q ? src_q : dst_q)
                    + (unit16_q ? STEP_WORD : STEP_BYTE);
                // Terminal count of zero gives reload+1 units: 64K bytes or 128K bytes
                if (cnt_cur_q == CNT_TERMINAL)
                begin
                    irq_q[cur_q] <= 1'b1;
                    cnt_q[cur_q] <= repeat_q ? cfg[cur_q].counter_reload
                                             : cnt_cur_q - 1'b1;
                end
                else
                    cnt_q[cur_q] <= cnt_cur_q - 1'b1;
            end
        end
    end

    // Bus drive; hold asks for the bus as soon as any channel has work
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            bus_hold_q <= 1'b0;
            bus_q <= '0;
        end
        else
        begin
            bus_hold_q <= (ready != '0) || (state_q != ST_IDLE && state_q != ST_UPD);
            bus_q.rd <= (state_q == ST_RD);
            bus_q.wr <= (state_q == ST_WR) && fifo_out_valid;
            if (state_q == ST_RD)
            begin
                bus_q.addr <= rd_addr;
                bus_q.be <= rd_byte ? (rd_addr[0] ? BE_HIGH : BE_LOW) : BE_WORD;
                bus_q.wdata <= DATA_RST;
            end
            else if (state_q == ST_WR && fifo_out_valid)
            begin
                bus_q.addr <= wr_addr;
                bus_q.be <= wr_byte ? (wr_addr[0] ? BE_HIGH : BE_LOW) : BE_WORD;
                bus_q.wdata <= wr_byte ? {wr_byte_val, wr_byte_val} : fifo_out_data;
            end
            else
                bus_q.be <= BE_NONE;
        end
    end
    assign bus_hold = bus_hold_q;
    assign bus_out = bus_q;
    // Status snapshot for software
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            status <= '0;
        else
        begin
            for (int ch = 0; ch < NUM_CH; ch++)
            begin
                status[ch].request_status_bit <= pend_q[ch];
                status[ch].active <= cfg[ch].channel_enable_bit && !done_q[ch];
                status[ch].cfg_error <= bad[ch];
                status[ch].done_irq <= irq_q[ch];
                status[ch].counter <= cnt_q[ch];
                status[ch].pointer <= ptr_q[ch];
            end
        end
    end
    // Read data waits here so a stalled write phase holds the read side off
    tcd_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(state_q == ST_PUSH),
        .in_ready(fifo_in_ready),
        .in_data(data_q),
        .out_valid(fifo_out_valid),
        .out_ready(state_q == ST_WWAIT && !(wr_split && !part_q)),
        .out_data(fifo_out_data)
    );
endmodule // tcd_engine

// File: tb/tcd_props.sv
// Property checker of the transfer engine
module tcd_props
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Configuration and strobes
    input tcd_pkg::tcd_cfg_t [tcd_pkg::NUM_CH-1:0] cfg,
    input tcd_pkg::tcd_cmd_t [tcd_pkg::NUM_CH-1:0] cmd,
    input wire logic [tcd_pkg::NUM_CH-1:0][tcd_pkg::SRC_W-1:0] periph_irq,
    // Bus and status
    input wire logic bus_hold,
    input tcd_pkg::tcd_bus_t bus_out,
    input tcd_pkg::tcd_stat_t [tcd_pkg::NUM_CH-1:0] status
);
    timeunit 1ns;
    timeprecision 1ns;
    import tcd_pkg::*;
    logic [4:0] off_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // Cycles with both channels disabled, saturating
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            off_q <= 5'h00;
        else if (cfg[0].channel_enable_bit || cfg[1].channel_enable_bit)
            off_q <= 5'h00;
        else if (off_q != 5'h1F)
            off_q <= off_q + 5'h01;
    end
    sequence s_read;
        ##[1:4] bus_out.rd;
    endsequence
    sequence s_write;
        ##[1:8] bus_out.wr;
    endsequence
    property p_steal;
        $rose(bus_hold) |-> s_read ##0 s_write;
    endproperty
    property p_own;
        (bus_out.rd || bus_out.wr) |-> bus_hold && !(bus_out.rd && bus_out.wr);
    endproperty
    property p_hold_en;
        $rose(bus_hold) |-> $past(cfg[0].channel_enable_bit || cfg[1].channel_enable_bit);
    endproperty
    property p_even_lane;
        (bus_out.rd || bus_out.wr) && !bus_out.addr[0] |-> bus_out.be[0];
    endproperty
    property p_odd_lane;
        (bus_out.rd || bus_out.wr) && bus_out.addr[0] |-> bus_out.be == BE_HIGH;
    endproperty
    property p_done;
        status[0].done_irq |=> !status[0].done_irq;
    endproperty
    property p_off;
        off_q >= 5'h10 |-> !bus_hold;
    endproperty
    property p_clear;
        cmd[0].status_clear && !cmd[0].sw_request && periph_irq[0] == '0
            |-> ##2 !status[0].request_status_bit;
    endproperty
    a_steal: assert property (p_steal) else $error("no read then write after bus grab");
    a_own: assert property (p_own) else $error("access without bus ownership");
    a_hold_en: assert property (p_hold_en) else $error("bus taken while disabled");
    a_even_lane: assert property (p_even_lane) else $error("even access lost low lane");
    a_odd_lane: assert property (p_odd_lane) else $error("odd access not high lane only");
    a_done: assert property (p_done) else $error("done pulse longer than one cycle");
    a_off: assert property (p_off) else $error("bus held while all disabled");
    a_clear: assert property (p_clear) else $error("status bit survived clear");
endmodule // tcd_props

bind tcd_engine tcd_props u_props (.clk(clk), .reset(reset), .cfg(cfg), .cmd(cmd),
    .periph_irq(periph_irq), .bus_hold(bus_hold), .bus_out(bus_out), .status(status));

// File: tb/tcd_mem.sv
// Memory model on the shared bus
module tcd_mem
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Bus from the engine
    input wire logic bus_hold,
    input tcd_pkg::tcd_bus_t bus_out,
    output logic [tcd_pkg::DATA_W-1:0] bus_rdata,
    // Access log
    output int rd_cnt,
    output int wr_cnt,
    output logic [tcd_pkg::ADDR_W-1:0] last_wr
);
    timeunit 1ns;
    timeprecision 1ns;
    import tcd_pkg::*;
    logic [7:0] mem [0:255];
    logic [7:0] a_q;
    logic rd_q;
    logic [DATA_W-1:0] last_q = 16'h0000;
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = i[7:0] ^ 8'hA5;
    end
    // Valid one cycle after rd, else junk
    assign bus_rdata = rd_q ? {mem[a_q | 8'h01], mem[a_q & 8'hFE]} : ~last_q;
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rd_q <= 1'b0;
            rd_cnt <= 0;
            wr_cnt <= 0;
            last_wr <= '0;
        end
        else
        begin
            // Processor stays off the bus while the engine holds it
            rd_q <= bus_hold && bus_out.rd;
            a_q <= bus_out.addr[7:0];
            if (rd_q)
                last_q <= bus_rdata;
            if (bus_hold && bus_out.rd)
                rd_cnt <= rd_cnt + 1;
            if (bus_hold && bus_out.wr)
            begin
                if (bus_out.be[0])
                    mem[bus_out.addr[7:0] & 8'hFE] <= bus_out.wdata[7:0];
                if (bus_out.be[1])
                    mem[bus_out.addr[7:0] | 8'h01] <= bus_out.wdata[15:8];
                wr_cnt <= wr_cnt + 1;
                last_wr <= bus_out.addr;
            end
        end
    end
endmodule // tcd_mem

// File: tb/tb_tcd_engine.sv
// Self-checking bench of the transfer engine
module tb_tcd_engine;
    timeunit 1ns;
    timeprecision 1ns;
    import tcd_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    tcd_cfg_t [NUM_CH-1:0] cfg = '0;
    tcd_cmd_t [NUM_CH-1:0] cmd = '0;
    logic pin0 = 1'b1;
    logic pin1 = 1'b1;
    logic [NUM_CH-1:0][SRC_W-1:0] pirq = '0;
    logic bus_hold;
    tcd_bus_t bus_out;
    logic [DATA_W-1:0] bus_rdata;
    tcd_stat_t [NUM_CH-1:0] status;
    logic [ADDR_W-1:0] last_wr;
    int rd_cnt, wr_cnt, w, r, d, cyc = 0, num_errors = 0, n_checks = 0;
    int done_cnt [NUM_CH] = '{0, 0};

    tcd_engine uut (.clk(clk), .reset(reset), .cfg(cfg), .cmd(cmd), .ext_irq_pin_zero(pin0),
        .ext_irq_pin_one(pin1), .periph_irq(pirq), .bus_hold(bus_hold), .bus_out(bus_out),
        .bus_rdata(bus_rdata), .status(status));
    tcd_mem u_mem (.clk(clk), .reset(reset), .bus_hold(bus_hold), .bus_out(bus_out),
        .bus_rdata(bus_rdata), .rd_cnt(rd_cnt), .wr_cnt(wr_cnt), .last_wr(last_wr));

    initial
    begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        for (int c = 0; c < NUM_CH; c++)
            if (status[c].done_irq === 1'b1)
                done_cnt[c]++;
        if (cyc == 20000)
        begin
            num_errors++;
            results();
        end
    end

    task automatic results;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    function automatic logic [7:0] f(input logic [7:0] a);
        return a ^ 8'hA5;
    endfunction
    function automatic tcd_cfg_t mk(input logic rep, ub, sf, df, input logic [4:0] sel,
        input logic [19:0] s, dd, input logic [15:0] rl);
        return {1'b1, rep, ub, sf, df, sel, s, dd, rl};
    endfunction
    task automatic put(input int ch, input tcd_cfg_t c);
        @(posedge clk);
        cfg[ch] <= c;
    endtask
    task automatic req(input int ch, input int n);
        @(posedge clk);
        cmd[ch].sw_request <= 1'b1;
        tick(n);
        cmd[ch].sw_request <= 1'b0;
    endtask
    // Bounded wait for writes, then settle
    task automatic wait_wr(input int tgt, input int post);
        for (int i = 0; i < 300 && wr_cnt < tgt; i++)
            @(posedge clk);
        tick(post);
    endtask
    task automatic off;
        @(posedge clk);
        cfg <= '0;
        tick(3);
    endtask

    task automatic t_word_single;
        w = wr_cnt;
        put(0, mk(0, 0, 1, 0, SRC_SOFTWARE, 20'h00010, 20'h00080, 16'h0001));
        req(0, 1);
        wait_wr(w + 1, 6);
        check({u_mem.mem[8'h81], u_mem.mem[8'h80]}, {f(8'h11), f(8'h10)});
        check(status[0].pointer, 20'h00012);
        check(status[0].counter, 16'h0000);
        req(0, 1);
        wait_wr(w + 2, 6);
        check(done_cnt[0], 1);
        check(status[0].active, 1'b0);
        req(0, 1);
        tick(30);
        check(wr_cnt, w + 2);
        off();
        $display("test word_single done");
    endtask
    task automatic t_odd_repeat;
        w = wr_cnt;
        r = rd_cnt;
        d = done_cnt[0];
        put(0, mk(1, 0, 0, 0, SRC_SOFTWARE, 20'h00021, 20'h00041, 16'h0000));
        req(0, 1);
        wait_wr(w + 2, 6);
        check(rd_cnt, r + 2);
        check(wr_cnt, w + 2);
        check({u_mem.mem[8'h42], u_mem.mem[8'h41]}, {f(8'h22), f(8'h21)});
        req(0, 1);
        wait_wr(w + 4, 6);
        check(done_cnt[0], d + 2);
        check(status[0].active, 1'b1);
        off();
        $display("test odd_repeat done");
    endtask
    task automatic t_byte;
        w = wr_cnt;
        put(1, mk(0, 1, 1, 0, SRC_SOFTWARE, 20'h00030, 20'h00061, 16'h0000));
        req(1, 1);
        wait_wr(w + 1, 6);
        check(u_mem.mem[8'h61], f(8'h30));
        check(u_mem.mem[8'h60], f(8'h60));
        check(status[1].pointer, 20'h00031);
        off();
        $display("test byte done");
    endtask
    task automatic t_prio;
        w = wr_cnt;
        put(0, mk(1, 0, 0, 0, SRC_SOFTWARE, 20'h00050, 20'h00090, 16'h0000));
        put(1, mk(1, 0, 0, 0, SRC_SOFTWARE, 20'h00052, 20'h00094, 16'h0000));
        @(posedge clk);
        cmd[0].sw_request <= 1'b1;
        cmd[1].sw_request <= 1'b1;
        @(posedge clk);
        cmd <= '0;
        wait_wr(w + 1, 0);
        check(last_wr, 20'h00090);
        wait_wr(w + 2, 0);
        check(last_wr, 20'h00094);
        req(0, 4);
        tick(40);
        check(wr_cnt, w + 4);
        off();
        $display("test prio done");
    endtask
    task automatic t_periph;
        for (int i = 2; i < 32; i++)
        begin
            if (i == 5'h17)
                continue;
            w = wr_cnt;
            put(1, mk(1, 1, 0, 0, i[4:0], 20'h70, 20'h72, 16'h0));
            tick(2);
            pirq[1][i ^ 1] <= 1'b1;
            tick(1);
            pirq[1] <= '0;
            tick(12);
            check(wr_cnt, w);
            pirq[1][i] <= 1'b1;
            tick(1);
            pirq[1] <= '0;
            wait_wr(w + 1, 2);
            check(wr_cnt, w + 1);
        end
        off();
        $display("test periph done");
    endtask
    task automatic t_pin;
        w = wr_cnt;
        put(0, mk(1, 0, 0, 0, SRC_PIN_FALL, 20'h00054, 20'h00098, 16'h0000));
        tick(2);
        pin0 <= 1'b0;
        wait_wr(w + 1, 2);
        pin0 <= 1'b1;
        tick(30);
        check(wr_cnt, w + 1);
        put(1, mk(1, 0, 0, 0, SRC_PIN_BOTH, 20'h54, 20'h98, 16'h0));
        tick(4);
        pin1 <= 1'b0;
        wait_wr(w + 2, 2);
        pin1 <= 1'b1;
        wait_wr(w + 3, 2);
        check(wr_cnt, w + 3);
        off();
        $display("test pin done");
    endtask
    task automatic t_disabled;
        tcd_cfg_t c;
        w = wr_cnt;
        c = mk(1, 0, 0, 0, SRC_SOFTWARE, 20'h00010, 20'h00084, 16'h0000);
        put(0, c);
        c.channel_enable_bit = 1'b0;
        put(0, c);
        req(0, 1);
        tick(30);
        check(wr_cnt, w);
        $display("test disabled done");
    endtask
    task automatic t_both_fwd;
        w = wr_cnt;
        put(0, mk(0, 0, 1, 1, SRC_SOFTWARE, 20'h00010, 20'h00084, 16'h0000));
        req(0, 1);
        tick(20);
        check(wr_cnt, w);
        check(status[0].cfg_error, 1'b1);
        check(status[0].request_status_bit, 1'b1);
        @(posedge clk);
        cmd[0].status_clear <= 1'b1;
        @(posedge clk);
        cmd[0].status_clear <= 1'b0;
        tick(4);
        check(status[0].request_status_bit, 1'b0);
        off();
        $display("test both_fwd done");
    endtask

    initial
    begin
        tick(20);
        reset <= 1'b0;
        tick(3);
        t_word_single();
        t_odd_repeat();
        t_byte();
        t_prio();
        t_periph();
        t_pin();
        t_disabled();
        t_both_fwd();
        results();
    end
endmodule // tb_tcd_engine
